// file: rtl/lpm_map.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 low-power mode controller. Assumes a 125 MHz system clock.
*/
`ifndef LPM_MAP_SVH
`define LPM_MAP_SVH

// ==========================================================
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_FLAG_CLR 8'h08
`define OFS_RISE 8'h0c
`define OFS_FALL 8'h10
`define OFS_INT_MASK 8'h14
`define OFS_EVT_MASK 8'h18
`define OFS_PEND 8'h1c
`define OFS_PINSEL0 8'h20
`define OFS_PINSEL3 8'h2c

// ==========================================================
// Field positions
`define CTRL_MODE_LSB 0
`define CTRL_LPREG 2
`define CTRL_PVD_EN 3
`define CTRL_EXT_CLK 4
`define CTRL_W 5
`define STAT_CSS_FAIL 8
`define STAT_SBY_FLAG 9

// ==========================================================
// Reset values
`define CTRL_RESET 5'h00
`define LINE_REG_RESET 32'h0000_0000
`define PINSEL_RESET 7'h00

// ==========================================================
// Sizes
`define GPIO_COUNT 87
`define PIN_LINES 16
`define LINE_COUNT 32
`define PINSEL_W 7
`define HSI_REQ_W 4

// ==========================================================
// Timing
`define CLK_FREQ_MHZ 125
`define CSS_TIMEOUT_NS 1000
`define CSS_TIMEOUT_CYC ((`CSS_TIMEOUT_NS * `CLK_FREQ_MHZ) / 1000)

`endif

// file: rtl/lpm_pkg.sv
/*
 Types of the low-power mode controller: power states and the bundle of
 power and clock controls. Assumes lpm_map.svh holds the numbers.
*/
package lpm_pkg;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_SLEEP,
        ST_STOP,
        ST_STANDBY
    } pwr_state_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic core_clk_en;
        logic pll_en;
        logic hsi_en;
        logic hse_en;
        logic reg_en;
        logic reg_lp;
        logic reg_hiz;
        logic core_pwr;
        logic sysclk_ext;
        logic always_on_clk_en;
        logic pvd_en;
    } pwr_ctrl_t;

endpackage

// file: rtl/low_power_mode_controller.sv
/*
 Low-power mode sequencer with 32-line edge-detect wakeup controller and
 external clock monitor, AHB-Lite register slave.
 Assumes: one 125 MHz clock, active-low async reset, core_sleep_req and
 periph_irq and hsi_req come from logic on the same clock; pins, internal
 line sources, the external clock and the wakeup sources are asynchronous.
*/
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "lpm_map.svh"

module low_power_mode_controller (
    input wire logic clock,
    input wire logic external_reset_pin,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic core_sleep_req,
    input wire logic periph_irq,
    input wire logic [`GPIO_COUNT-1:0] gpio_in,
    input wire logic [`LINE_COUNT-`PIN_LINES-1:0] int_line_src,
    input wire logic [`HSI_REQ_W-1:0] hsi_req,
    input wire logic hse_clk,
    input wire logic wakeup_pin,
    input wire logic cal_event,
    input wire logic external_reset_pin_n,
    input wire logic wdg_reset,
    output lpm_pkg::pwr_ctrl_t pwr,
    output logic [`HSI_REQ_W-1:0] hsi_grant,
    output logic [`LINE_COUNT-1:0] line_irq,
    output logic [`LINE_COUNT-1:0] line_evt,
    output logic wake
);
    import lpm_pkg::*;

    localparam int SYNC_W = 2 * `LINE_COUNT + 5;

    pwr_state_t st_q, st_d;
    pwr_ctrl_t pwr_q;
    logic [`CTRL_W-1:0] ctrl_q;
    logic [`LINE_COUNT-1:0] rise_q, fall_q, imr_q, emr_q, pend_q, pend_d;
    logic [`PIN_LINES-1:0][`PINSEL_W-1:0] pinsel_q;
    logic css_fail_q, sby_flag_q;
    logic [7:0] css_cnt_q;
    logic [`HSI_REQ_W-1:0] grant_q;
    logic [`LINE_COUNT-1:0] irq_q, evt_q;
    logic wake_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q, hresp_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    wire [`LINE_COUNT-1:0] line_src, rise_tgl, fall_tgl;
    logic [SYNC_W-1:0] s1_q, s2_q, s3_q;
    logic [`LINE_COUNT-1:0] trig;
    logic any_wake, sby_wake, sby_exit, hse_edge, wr_en;

    // ==========================================================
    // Line sources and asynchronous edge capture
    genvar g;
    generate
        for (g = 0; g < `LINE_COUNT; g++) begin : g_line
            logic r_t, f_t;
            if (g < `PIN_LINES) begin : g_pin
                assign line_src[g] = (pinsel_q[g] < 7'(`GPIO_COUNT)) ? gpio_in[pinsel_q[g]] : 1'b0;
            end else if (g == `PIN_LINES) begin : g_pvd
                assign line_src[g] = int_line_src[0] & ctrl_q[`CTRL_PVD_EN];
            end else begin : g_int
                assign line_src[g] = int_line_src[g-`PIN_LINES];
            end
            // Each edge flips a toggle clocked by the line itself
            always_ff @(posedge line_src[g] or negedge external_reset_pin) begin
                if (!external_reset_pin) begin
                    r_t <= 1'b0;
                end else begin
                    r_t <= ~r_t;
                end
            end
            always_ff @(negedge line_src[g] or negedge external_reset_pin) begin
                if (!external_reset_pin) begin
                    f_t <= 1'b0;
                end else begin
                    f_t <= ~f_t;
                end
            end
            assign rise_tgl[g] = r_t;
            assign fall_tgl[g] = f_t;
        end
    endgenerate

    // ==========================================================
    // Synchronisers; third stage only for change detection
    // Two edges of one kind within the sync window cancel out.
    always_ff @(posedge clock or negedge external_reset_pin) begin
        if (!external_reset_pin) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= {rise_tgl, fall_tgl, hse_clk, wakeup_pin, cal_event, ~external_reset_pin_n, wdg_reset};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_comb begin
        trig = ((s2_q[SYNC_W-1 -: `LINE_COUNT] ^ s3_q[SYNC_W-1 -: `LINE_COUNT]) & rise_q)
             | ((s2_q[`LINE_COUNT+4 -: `LINE_COUNT] ^ s3_q[`LINE_COUNT+4 -: `LINE_COUNT]) & fall_q);
        any_wake = |(trig & (imr_q | emr_q));
        hse_edge = s2_q[4] ^ s3_q[4];
        sby_wake = (s2_q[3] & ~s3_q[3]) | (s2_q[2] & ~s3_q[2]) | s2_q[1] | s2_q[0];
        sby_exit = (st_q == ST_STANDBY) && sby_wake;
    end

    // ==========================================================
    // Power state sequencing
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_RUN: begin
                if (core_sleep_req) begin
                    st_d = pwr_state_t'(ctrl_q[`CTRL_MODE_LSB +: 2]);
                end
            end
            ST_SLEEP: begin
                if (periph_irq || any_wake) begin
                    st_d = ST_RUN;
                end
            end
            ST_STOP: begin
                if (any_wake) begin
                    st_d = ST_RUN;
                end
            end
            ST_STANDBY: begin
                if (sby_wake) begin
                    st_d = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge external_reset_pin) begin
        if (!external_reset_pin) begin
            st_q <= ST_RUN;
        end else begin
            st_q <= st_d;
        end
    end

    // Reset values: regulator on in main mode, internal RC as system clock
    always_ff @(posedge clock or negedge external_reset_pin) begin
        if (!external_reset_pin) begin
            pwr_q <= '{cpu_clk_en: 1'b1, core_clk_en: 1'b1, pll_en: 1'b1, hsi_en: 1'b1, hse_en: 1'b0,
                       reg_en: 1'b1, reg_lp: 1'b0, reg_hiz: 1'b0, core_pwr: 1'b1, sysclk_ext: 1'b0,
                       always_on_clk_en: 1'b1, pvd_en: 1'b0};
        end else begin
            pwr_q.cpu_clk_en <= (st_d == ST_RUN);
            pwr_q.core_clk_en <= (st_d == ST_RUN) || (st_d == ST_SLEEP);
            pwr_q.pll_en <= (st_d == ST_RUN) || (st_d == ST_SLEEP);
            pwr_q.hsi_en <= (st_d == ST_RUN) || (st_d == ST_SLEEP)
                         || ((st_d == ST_STOP) && (|hsi_req) && !pwr_q.reg_lp);
            pwr_q.hse_en <= ((st_d == ST_RUN) || (st_d == ST_SLEEP)) && ctrl_q[`CTRL_EXT_CLK];
            pwr_q.reg_en <= (st_d != ST_STANDBY);
            pwr_q.reg_lp <= (st_d == ST_STOP) && ctrl_q[`CTRL_LPREG] && !(|hsi_req);
            pwr_q.reg_hiz <= (st_d == ST_STANDBY);
            pwr_q.core_pwr <= (st_d != ST_STANDBY);
            pwr_q.sysclk_ext <= ((st_d == ST_RUN) || (st_d == ST_SLEEP)) && ctrl_q[`CTRL_EXT_CLK]
                             && !css_fail_q;
            pwr_q.always_on_clk_en <= 1'b1;
            pwr_q.pvd_en <= ctrl_q[`CTRL_PVD_EN];
        end
    end

    // RC clock reaches a Stop-mode peripheral only after main regulator is back
    always_ff @(posedge clock or negedge external_reset_pin) begin
        if (!external_reset_pin) begin
            grant_q <= '0;
        end else begin
            grant_q <= hsi_req & {`HSI_REQ_W{(st_q != ST_STANDBY) && !pwr_q.reg_lp}};
        end
    end

    // ==========================================================
    // External clock monitor
    always_ff @(posedge clock or negedge external_reset_pin) begin
        if (!external_reset_pin) begin
            css_cnt_q <= 8'h00;
        end else if (!pwr_q.sysclk_ext || hse_edge) begin
            css_cnt_q <= 8'h00;
        end else if (css_cnt_q != 8'(`CSS_TIMEOUT_CYC)) begin
            css_cnt_q <= css_cnt_q + 8'h01;
        end
    end

    // Sticky flags: hardware set wins over a software clear
    always_ff @(posedge clock or negedge external_reset_pin) begin
        if (!external_reset_pin) begin
            css_fail_q <= 1'b0;
            sby_flag_q <= 1'b0;
        end else begin
            css_fail_q <= (pwr_q.sysclk_ext && (css_cnt_q == 8'(`CSS_TIMEOUT_CYC)))
                       || (css_fail_q && !(wr_en && wr_addr_q == `OFS_FLAG_CLR && hwdata[`STAT_CSS_FAIL]));
            sby_flag_q <= sby_exit
                       || (sby_flag_q && !(wr_en && wr_addr_q == `OFS_FLAG_CLR && hwdata[`STAT_SBY_FLAG]));
        end
    end

    // ==========================================================
    // Line registers; wiped on Standby exit as the core lost power
    assign wr_en = wr_pend_q;

    always_ff @(posedge clock or negedge external_reset_pin) begin
        if (!external_reset_pin) begin
            ctrl_q <= `CTRL_RESET;
            rise_q <= `LINE_REG_RESET;
            fall_q <= `LINE_REG_RESET;
            imr_q <= `LINE_REG_RESET;
            emr_q <= `LINE_REG_RESET;
            pinsel_q <= '0;
        end else if (sby_exit) begin
            ctrl_q <= `CTRL_RESET;
            rise_q <= `LINE_REG_RESET;
            fall_q <= `LINE_REG_RESET;
            imr_q <= `LINE_REG_RESET;
            emr_q <= `LINE_REG_RESET;
            pinsel_q <= '0;
        end else if (wr_en) begin
            if (wr_addr_q == `OFS_CTRL) begin
                ctrl_q <= hwdata[`CTRL_W-1:0];
            end
            if (wr_addr_q == `OFS_RISE) begin
                rise_q <= hwdata;
            end
            if (wr_addr_q == `OFS_FALL) begin
                fall_q <= hwdata;
            end
            if (wr_addr_q == `OFS_INT_MASK) begin
                imr_q <= hwdata;
            end
            if (wr_addr_q == `OFS_EVT_MASK) begin
                emr_q <= hwdata;
            end
            if (wr_addr_q >= `OFS_PINSEL0 && wr_addr_q <= `OFS_PINSEL3) begin
                for (int k = 0; k < 4; k++) begin
                    pinsel_q[{wr_addr_q[3:2], 2'(k)}] <= hwdata[k*8 +: `PINSEL_W];
                end
            end
        end
    end

    always_comb begin
        pend_d = pend_q;
        if (wr_en && wr_addr_q == `OFS_PEND) begin
            pend_d = pend_q & ~hwdata;
        end
        pend_d = pend_d | (trig & imr_q);
    end

    always_ff @(posedge clock or negedge external_reset_pin) begin
        if (!external_reset_pin) begin
            pend_q <= `LINE_REG_RESET;
            irq_q <= `LINE_REG_RESET;
            evt_q <= `LINE_REG_RESET;
            wake_q <= 1'b0;
        end else begin
            pend_q <= sby_exit ? `LINE_REG_RESET : pend_d;
            irq_q <= sby_exit ? `LINE_REG_RESET : pend_d;
            evt_q <= trig & emr_q;
            wake_q <= any_wake || sby_wake;
        end
    end

    // ==========================================================
    // AHB-Lite slave, zero wait states
    // Reads sample at the address phase, so a read right after a
    // write to the same register returns the old value.
    always_ff @(posedge clock or negedge external_reset_pin) begin
        if (!external_reset_pin) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else if (hready) begin
            wr_pend_q <= hsel && htrans[1] && hwrite;
            wr_addr_q <= {haddr[7:2], 2'b00};
            hrdata_q <= 32'h0000_0000;
            if (hsel && htrans[1] && !hwrite) begin
                unique case ({haddr[7:2], 2'b00})
                    `OFS_CTRL: hrdata_q <= {27'h0, ctrl_q};
                    `OFS_STATUS: hrdata_q <= {22'h0, sby_flag_q, css_fail_q, 4'h0, pwr_q.sysclk_ext,
                                              pwr_q.reg_lp, 2'(st_q)};
                    `OFS_RISE: hrdata_q <= rise_q;
                    `OFS_FALL: hrdata_q <= fall_q;
                    `OFS_INT_MASK: hrdata_q <= imr_q;
                    `OFS_EVT_MASK: hrdata_q <= emr_q;
                    `OFS_PEND: hrdata_q <= pend_q;
                    8'h20, 8'h24, 8'h28, `OFS_PINSEL3: begin
                        for (int k = 0; k < 4; k++) begin
                            hrdata_q[k*8 +: 8] <= {1'b0, pinsel_q[{haddr[3:2], 2'(k)}]};
                        end
                    end
                    default: hrdata_q <= 32'h0000_0000;
                endcase
            end
        end else begin
            wr_pend_q <= 1'b0;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign pwr = pwr_q;
    assign hsi_grant = grant_q;
    assign line_irq = irq_q;
    assign line_evt = evt_q;
    assign wake = wake_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!external_reset_pin);

    sequence s_lp_stop_req;
        (st_q == ST_STOP) && pwr_q.reg_lp && (|hsi_req);
    endsequence

    sequence s_main_then_clock;
        (!pwr_q.reg_lp && grant_q == '0) ##1 (!pwr_q.reg_lp);
    endsequence

    AST_REG_ON_OUTSIDE_STANDBY: assert property ((st_q != ST_STANDBY) |-> (pwr_q.reg_en && !pwr_q.reg_hiz))
        else $error("regulator off outside standby");
    AST_LP_ONLY_IN_STOP: assert property (pwr_q.reg_lp |-> (st_q == ST_STOP))
        else $error("low-power regulator outside stop");
    AST_SLEEP_CPU_ONLY: assert property ((st_q == ST_SLEEP) |-> (!pwr_q.cpu_clk_en && pwr_q.core_clk_en))
        else $error("sleep gates more than the processor");
    AST_STOP_CLOCKS_OFF: assert property ((st_q == ST_STOP) |-> !(pwr_q.core_clk_en || pwr_q.pll_en || pwr_q.hse_en))
        else $error("clock running in stop");
    AST_MAIN_BEFORE_CLOCK: assert property (s_lp_stop_req ##1 (|hsi_req) |-> s_main_then_clock)
        else $error("clock delivered before main regulator");
    AST_STANDBY_ALL_OFF: assert property ((st_q == ST_STANDBY) |-> !(pwr_q.hsi_en || pwr_q.hse_en || pwr_q.pll_en
                                          || pwr_q.core_pwr || pwr_q.reg_en))
        else $error("standby left something powered");
    AST_STOP_WAKEUP: assert property (((st_q == ST_STOP) && any_wake) |=> ((st_q == ST_RUN) && wake_q))
        else $error("stop did not wake on an enabled line");
    AST_STANDBY_EXIT: assert property (sby_exit |=> (st_q == ST_RUN) && sby_flag_q && ctrl_q == '0 && pend_q == '0)
        else $error("standby exit incomplete");
    AST_MASKED_NO_PENDING: assert property (##1 ((pend_q & ~$past(pend_q) & ~$past(imr_q)) == '0))
        else $error("masked line set pending");
    AST_CSS_FALLBACK: assert property ($rose(css_fail_q) |-> ##1 !pwr_q.sysclk_ext ##1 !pwr_q.hse_en || ctrl_q[`CTRL_EXT_CLK])
        else $error("no fallback after clock failure");
    AST_ALWAYS_ON_CLOCKS: assert property (pwr_q.always_on_clk_en)
        else $error("always-on clocks stopped");

endmodule // low_power_mode_controller

// file: tb/lpm_partner.sv
/*
 Far-side model: external clock source and general-purpose pins.
 Assumes the bench starts and stops the clock and asks for pin pulses.
*/
`timescale 1ns/1ps
`include "lpm_map.svh"

module lpm_partner (
    input wire logic ext_run,
    output logic hse_clk,
    output logic [`GPIO_COUNT-1:0] gpio
);
    initial begin
        hse_clk = 1'b0;
        gpio = '0;
    end

    // ==========================================================
    // 10 MHz external clock, stands still when stopped to model a failure
    always begin
        #50;
        if (ext_run) begin
            hse_clk = ~hse_clk;
        end
    end

    // ==========================================================
    // Pulse narrower than one system clock period
    task automatic pin_pulse(input int idx);
        #2 gpio[idx] = 1'b1;
        #3 gpio[idx] = 1'b0;
    endtask
endmodule // lpm_partner

// file: tb/low_power_mode_controller_bench.sv
/*
 Self-checking bench of the low-power mode controller.
 Assumes the AHB-Lite slave answers with zero wait states.
*/
`timescale 1ns/1ps
`include "lpm_map.svh"

module low_power_mode_controller_bench;
    import lpm_pkg::*;
    logic clock = 1'b0, external_reset_pin = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic hreadyout, hresp, core_sleep_req = 1'b0, periph_irq = 1'b0;
    logic [15:0] int_line_src = '0;
    logic [3:0] hsi_req = '0, hsi_grant;
    logic hse_clk, wakeup_pin = 1'b0, cal_event = 1'b0, ext_rst_n = 1'b1, wdg_reset = 1'b0;
    logic ext_run = 1'b0, wake;
    logic [86:0] gpio;
    logic [31:0] line_irq, line_evt, rd;
    pwr_ctrl_t pwr;
    int n_fail = 0, n_tests = 0;

    assign hready = hreadyout;
    always #4 clock = ~clock;

    low_power_mode_controller DUT (.clock(clock), .external_reset_pin(external_reset_pin), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .core_sleep_req(core_sleep_req),
        .periph_irq(periph_irq), .gpio_in(gpio), .int_line_src(int_line_src), .hsi_req(hsi_req),
        .hse_clk(hse_clk), .wakeup_pin(wakeup_pin), .cal_event(cal_event),
        .external_reset_pin_n(ext_rst_n), .wdg_reset(wdg_reset), .pwr(pwr),
        .hsi_grant(hsi_grant), .line_irq(line_irq), .line_evt(line_evt), .wake(wake));
    lpm_partner partner (.ext_run(ext_run), .hse_clk(hse_clk), .gpio(gpio));

    // ==========================================================
    // Checking and bus helpers
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask

    task automatic enter_mode(input logic [31:0] ctrl);
        bus(1'b1, `OFS_CTRL, ctrl);
        @(posedge clock) core_sleep_req <= 1'b1;
        @(posedge clock) core_sleep_req <= 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic wait_run();
        for (int i = 0; i < 20 && pwr.cpu_clk_en !== 1'b1; i++) @(posedge clock);
        #1;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        check("pwr_reset", {20'h0, pwr}, 32'hf4a);
        check("bus_idle", {30'h0, hreadyout, hresp}, 32'h2);
        rd_chk("ctrl_reset", `OFS_CTRL, 32'h0);
        rd_chk("unmapped", 8'h30, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_sleep();
        enter_mode(32'h1);
        check("pwr_sleep", {20'h0, pwr}, 32'h74a);
        @(posedge clock) periph_irq <= 1'b1;
        @(posedge clock) periph_irq <= 1'b0;
        @(posedge clock);
        #1 check("pwr_sleep_exit", {20'h0, pwr}, 32'hf4a);
        $display("test sleep done");
    endtask

    task automatic t_stop();
        bus(1'b1, `OFS_PINSEL0, 32'h0000_0605);
        bus(1'b1, `OFS_RISE, 32'h3);
        bus(1'b1, `OFS_INT_MASK, 32'h1);
        enter_mode(32'h6);
        check("pwr_stop", {20'h0, pwr}, 32'h06a);
        @(posedge clock) hsi_req <= 4'h1;
        @(posedge clock);
        #1 check("rc_step1", {20'h0, pwr}, 32'h04a);
        @(posedge clock);
        #1 check("rc_step2", {20'h0, pwr}, 32'h14a);
        check("rc_grant", {28'h0, hsi_grant}, 32'h1);
        @(posedge clock) hsi_req <= 4'h0;
        partner.pin_pulse(6);
        repeat (8) @(posedge clock);
        #1 check("masked_stays", {31'h0, pwr.cpu_clk_en}, 32'h0);
        partner.pin_pulse(5);
        wait_run();
        check("stop_wake", {20'h0, pwr}, 32'hf4a);
        check("irq_stop", line_irq, 32'h1);
        rd_chk("pend_set", `OFS_PEND, 32'h1);
        bus(1'b1, `OFS_PEND, 32'h1);
        rd_chk("pend_clr", `OFS_PEND, 32'h0);
        check("irq_cleared", line_irq, 32'h0);
        $display("test stop done");
    endtask

    task automatic t_edges();
        bus(1'b1, `OFS_RISE, 32'h1_0000);
        bus(1'b1, `OFS_FALL, 32'h2_0000);
        bus(1'b1, `OFS_INT_MASK, 32'h3_0000);
        @(posedge clock) int_line_src <= 16'h3;
        repeat (6) @(posedge clock);
        rd_chk("rise_ignored", `OFS_PEND, 32'h0);
        @(posedge clock) int_line_src <= 16'h0;
        repeat (6) @(posedge clock);
        rd_chk("fall_seen", `OFS_PEND, 32'h2_0000);
        bus(1'b1, `OFS_PEND, 32'h2_0000);
        bus(1'b1, `OFS_RISE, 32'h3_0000);
        bus(1'b1, `OFS_CTRL, 32'h8);
        @(posedge clock) int_line_src <= 16'h3;
        repeat (6) @(posedge clock);
        rd_chk("both_edges", `OFS_PEND, 32'h3_0000);
        check("irq_edges", line_irq, 32'h3_0000);
        // Event pulse and wake stand for one cycle only, so wait edge by edge
        bus(1'b1, `OFS_EVT_MASK, 32'h2_0000);
        @(posedge clock) int_line_src <= 16'h0;
        for (int i = 0; i < 10 && line_evt !== 32'h2_0000; i++) @(posedge clock);
        check("evt_pulse", line_evt, 32'h2_0000);
        check("wake_pulse", {31'h0, wake}, 32'h1);
        @(posedge clock);
        #1 check("evt_one_cycle", line_evt, 32'h0);
        $display("test edges done");
    endtask

    task automatic t_standby();
        for (int k = 0; k < 4; k++) begin
            enter_mode(32'h3);
            check("pwr_standby", {20'h0, pwr}, 32'h012);
            @(posedge clock);
            case (k)
                0: ext_rst_n <= 1'b0;
                1: wdg_reset <= 1'b1;
                2: wakeup_pin <= 1'b1;
                default: cal_event <= 1'b1;
            endcase
            repeat (3) @(posedge clock);
            {ext_rst_n, wdg_reset, wakeup_pin, cal_event} <= 4'b1000;
            wait_run();
            check("standby_exit", {31'h0, pwr.cpu_clk_en}, 32'h1);
            rd_chk("ctrl_wiped", `OFS_CTRL, 32'h0);
            rd_chk("sby_flag", `OFS_STATUS, 32'h200);
            bus(1'b1, `OFS_FLAG_CLR, 32'h200);
        end
        $display("test standby done");
    endtask

    task automatic t_clock_mon();
        ext_run <= 1'b1;
        bus(1'b1, `OFS_CTRL, 32'h10);
        repeat (200) @(posedge clock);
        #1 check("ext_selected", {31'h0, pwr.sysclk_ext}, 32'h1);
        ext_run <= 1'b0;
        for (int i = 0; i < 300 && pwr.sysclk_ext !== 1'b0; i++) @(posedge clock);
        #1 check("fallback", {31'h0, pwr.sysclk_ext}, 32'h0);
        rd_chk("css_flag", `OFS_STATUS, 32'h100);
        $display("test clock monitor done");
    endtask

    // ==========================================================
    // Verdict
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clock);
        external_reset_pin <= 1'b1;
        @(posedge clock);
        #1;
        t_reset();
        t_sleep();
        t_stop();
        t_edges();
        t_standby();
        t_clock_mon();
        wrap_up();
    end

    // Whole run is near 550 cycles; allow ample margin
    initial begin
        #100000;
        n_fail++;
        wrap_up();
    end
endmodule // low_power_mode_controller_bench
